// ### verilog/cssu_clock_startup.sv
`timescale 1ns/100ps
module cssu_clock_startup #(
  parameter logic [16:0] WAKE_16K = 17'h04000,
  parameter logic [16:0] WAKE_32K = 17'h08000,
  parameter logic [16:0] WDT_LONG = 17'h10000
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // fuse pins
  input  wire logic [3:0]  clockSourceSelectFuses,
  input  wire logic [1:0]  startupTimeFuses,
  input  wire logic        divideByEightFuse,
  // oscillator and wake pins
  input  wire logic        srcOscIn,
  input  wire logic        wdtOscIn,
  input  wire logic        extIntIn,
  input  wire logic        startCondIn,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // clock domain enables and reset hold
  output logic             coreHold,
  output logic             coreClkEn,
  output logic             ioClkEn,
  output logic             flashClkEn,
  output logic             asyClkEn,
  output logic             adcClkEn,
  output logic             sysClkEn
);

  typedef enum logic [2:0] {ST_LOAD, ST_ARM, ST_RSRC, ST_RWDT, ST_RUN, ST_SLEEP, ST_WAKE} cssu_state_t;

  localparam int PIN_SRC = 0;
  localparam int PIN_WDT = 1;
  localparam int PIN_INT = 2;
  localparam int PIN_START = 3;

  cssu_state_t         state_r;
  cssu_state_t         stNxt;
  cssu_pkg::cssu_mode_t mode_r;
  cssu_pkg::cssu_src_t srcKind;
  logic [9:0]          fuseMeta_r;
  logic [9:0]          fuseSync_r;
  logic [3:0]          srcSel_r;
  logic [1:0]          sutSel_r;
  logic                div8Fuse_r;
  logic [3:0]          pinMeta_r;
  logic [3:0]          pinSync_r;
  logic [1:0]          oscPrev_r;
  logic                srcTick;
  logic                wdtTick;
  logic                wakeEvt;
  logic                deepSleep;
  logic                srcLoad;
  logic [16:0]         srcVal;
  logic                srcDone;
  logic                wdtDone;
  logic [2:0]          crystalRange;
  logic [16:0]         wakeCycles;
  logic [16:0]         wdtCycles;
  logic                badCode;
  logic                asyEnable_r;
  logic                intPend_r;
  logic                startPend_r;
  logic [2:0]          divCnt_r;
  logic [31:0]         rdVal;
  logic                addrHit;
  logic                apbWrite;

  ////////////////////////////////////////////////////////////////
  // pin synchronisers
  // fuse flops run through reset, so the shadow sees settled pins when reset lifts
  always_ff @(posedge core_clk) begin
    fuseMeta_r <= {3'h7, divideByEightFuse, startupTimeFuses, clockSourceSelectFuses};
    fuseSync_r <= fuseMeta_r;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta_r  <= 4'h0;
      pinSync_r  <= 4'h0;
      oscPrev_r  <= 2'h0;
    end else begin
      pinMeta_r  <= {startCondIn, extIntIn, wdtOscIn, srcOscIn};
      pinSync_r  <= pinMeta_r;
      oscPrev_r  <= pinSync_r[PIN_WDT:PIN_SRC];
    end
  end

  assign srcTick = pinSync_r[PIN_SRC] & ~oscPrev_r[PIN_SRC];
  assign wdtTick = pinSync_r[PIN_WDT] & ~oscPrev_r[PIN_WDT];
  // sampled on core_clk regardless of the io enable, so wake still works in sleep
  assign wakeEvt = pinSync_r[PIN_INT] | pinSync_r[PIN_START];

  ////////////////////////////////////////////////////////////////
  // fuse shadow, caught once after reset release
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      srcSel_r   <= cssu_pkg::DEF_SRC_SEL;
      sutSel_r   <= cssu_pkg::DEF_STARTUP;
      div8Fuse_r <= cssu_pkg::DEF_DIV8;
    end else if (state_r == ST_LOAD) begin
      srcSel_r   <= fuseSync_r[3:0];
      sutSel_r   <= fuseSync_r[5:4];
      div8Fuse_r <= fuseSync_r[6];
    end
  end

  cssu_fuse_decode #(
    .WAKE_16K (WAKE_16K),
    .WAKE_32K (WAKE_32K),
    .WDT_LONG (WDT_LONG)
  ) u_decode (
    .srcSel       (srcSel_r),
    .sutSel       (sutSel_r),
    .srcKind      (srcKind),
    .crystalRange (crystalRange),
    .wakeCycles   (wakeCycles),
    .wdtCycles    (wdtCycles),
    .badCode      (badCode)
  );

  ////////////////////////////////////////////////////////////////
  // start-up sequencer
  assign deepSleep = (mode_r == cssu_pkg::MODE_PDOWN) || (mode_r == cssu_pkg::MODE_PSAVE);

  always_comb begin
    stNxt   = state_r;
    srcLoad = 1'b0;
    srcVal  = cssu_pkg::RST_SRC_14;
    case (state_r)
      ST_LOAD: stNxt = ST_ARM;
      ST_ARM: begin
        stNxt   = ST_RSRC;
        srcLoad = 1'b1;
      end
      ST_RSRC: if (srcDone) stNxt = ST_RWDT;
      ST_RWDT: if (wdtDone) stNxt = ST_RUN;
      ST_RUN: if (mode_r != cssu_pkg::MODE_RUN) stNxt = ST_SLEEP;
      ST_SLEEP: begin
        if (wakeEvt && deepSleep) begin
          stNxt   = ST_WAKE;
          srcLoad = 1'b1;
          srcVal  = wakeCycles;
        end else if (wakeEvt) begin
          stNxt = ST_RUN;
        end
      end
      ST_WAKE: if (srcDone) stNxt = ST_RUN;
      default: stNxt = ST_LOAD;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_LOAD;
    end else begin
      state_r <= stNxt;
    end
  end

  cssu_cycle_counter #(.W(cssu_pkg::CNT_W)) u_srcCount (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .load     (srcLoad),
    .loadVal  (srcVal),
    .tick     (srcTick),
    .done     (srcDone)
  );

  cssu_cycle_counter #(.W(cssu_pkg::CNT_W)) u_wdtCount (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .load     (state_r == ST_ARM),
    .loadVal  (wdtCycles),
    .tick     (wdtTick && state_r == ST_RWDT),
    .done     (wdtDone)
  );

  ////////////////////////////////////////////////////////////////
  // clock domain enables
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      coreHold   <= 1'b1;
      coreClkEn  <= 1'b0;
      ioClkEn    <= 1'b0;
      flashClkEn <= 1'b0;
      adcClkEn   <= 1'b0;
      asyClkEn   <= 1'b0;
    end else begin
      coreHold   <= (stNxt != ST_RUN) && (stNxt != ST_SLEEP);
      coreClkEn  <= (state_r == ST_RUN);
      flashClkEn <= (state_r == ST_RUN);
      ioClkEn    <= (state_r == ST_RUN) ||
                    (state_r == ST_SLEEP && mode_r == cssu_pkg::MODE_IDLE);
      adcClkEn   <= (state_r == ST_RUN) ||
                    (state_r == ST_SLEEP && (mode_r == cssu_pkg::MODE_IDLE ||
                                             mode_r == cssu_pkg::MODE_ADCNR));
      asyClkEn   <= asyEnable_r;
    end
  end

  // the prescaler stays free running; only its output pulse is gated
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_r <= 3'h0;
      sysClkEn <= 1'b0;
    end else begin
      divCnt_r <= divCnt_r + 3'h1;
      sysClkEn <= (div8Fuse_r == cssu_pkg::FUSE_PROG) ? (divCnt_r == cssu_pkg::DIV8_LAST) : 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // apb slave, answers in the first access cycle
  assign apbWrite = psel && penable && pready && pwrite;

  always_comb begin
    rdVal   = 32'h0;
    addrHit = 1'b1;
    case (paddr)
      cssu_pkg::ADDR_CTRL: begin
        rdVal[2:0]                   = mode_r;
        rdVal[cssu_pkg::CTRL_ASY_BIT] = asyEnable_r;
      end
      cssu_pkg::ADDR_STAT: begin
        rdVal[cssu_pkg::STAT_HOLD]        = coreHold;
        rdVal[cssu_pkg::STAT_BAD]         = badCode;
        rdVal[cssu_pkg::STAT_KIND +: 2]   = srcKind;
        rdVal[cssu_pkg::STAT_RANGE +: 3]  = crystalRange;
        rdVal[cssu_pkg::STAT_INT]         = intPend_r;
        rdVal[cssu_pkg::STAT_START]       = startPend_r;
        rdVal[cssu_pkg::STAT_DIV8]        = (div8Fuse_r == cssu_pkg::FUSE_PROG);
      end
      cssu_pkg::ADDR_FUSE: begin
        rdVal[cssu_pkg::FUSE_SEL +: 4] = srcSel_r;
        rdVal[cssu_pkg::FUSE_SUT +: 2] = sutSel_r;
        rdVal[cssu_pkg::FUSE_DIV8]     = div8Fuse_r;
      end
      default: addrHit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0 : rdVal;
      pslverr <= !addrHit;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // a software write wins over the wake clear of the mode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r      <= cssu_pkg::cssu_mode_t'(cssu_pkg::CTRL_RESET[2:0]);
      asyEnable_r <= cssu_pkg::CTRL_RESET[cssu_pkg::CTRL_ASY_BIT];
    end else if (apbWrite && paddr == cssu_pkg::ADDR_CTRL) begin
      mode_r      <= (pwdata[2:0] > 3'h4) ? cssu_pkg::MODE_RUN : cssu_pkg::cssu_mode_t'(pwdata[2:0]);
      asyEnable_r <= pwdata[cssu_pkg::CTRL_ASY_BIT];
    end else if (state_r == ST_SLEEP && wakeEvt) begin
      mode_r <= cssu_pkg::MODE_RUN;
    end
  end

  // sticky wake causes, write one to clear; a new event wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      intPend_r   <= 1'b0;
      startPend_r <= 1'b0;
    end else begin
      if (pinSync_r[PIN_INT]) intPend_r <= 1'b1;
      else if (apbWrite && paddr == cssu_pkg::ADDR_STAT && pwdata[cssu_pkg::STAT_INT]) intPend_r <= 1'b0;
      if (pinSync_r[PIN_START]) startPend_r <= 1'b1;
      else if (apbWrite && paddr == cssu_pkg::ADDR_STAT && pwdata[cssu_pkg::STAT_START]) startPend_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  sequence sleepExtInt;
    state_r == ST_SLEEP && pinSync_r[PIN_INT];
  endsequence
  sequence sleepStart;
    state_r == ST_SLEEP && pinSync_r[PIN_START];
  endsequence

  chk_core_halt: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_r == ST_SLEEP |=> !coreClkEn && !flashClkEn) else $error("core clock runs in sleep");
  chk_ext_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
    sleepExtInt |=> state_r != ST_SLEEP && intPend_r) else $error("external interrupt missed in sleep");
  chk_start_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
    sleepStart |=> state_r != ST_SLEEP && startPend_r) else $error("start condition missed in sleep");
  chk_flash_core: assert property (@(posedge core_clk) disable iff (!rst_n)
    flashClkEn == coreClkEn) else $error("flash clock differs from core clock");
  chk_asy_sleep: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_r == ST_SLEEP && asyEnable_r ##1 asyEnable_r |=> asyClkEn) else $error("async timer stopped in sleep");
  chk_adc_noise: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_r == ST_SLEEP && mode_r == cssu_pkg::MODE_ADCNR |=> adcClkEn && !ioClkEn) else $error("adc domain wrong");
  chk_src_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
    srcSel_r == cssu_pkg::SEL_EXT && sutSel_r != 2'h3 |-> srcKind == cssu_pkg::SRC_EXT) else $error("bad decode");
  chk_wdt_short: assert property (@(posedge core_clk) disable iff (!rst_n)
    srcSel_r == 4'h8 && sutSel_r == 2'h0 |-> wdtCycles == 17'h01000) else $error("short time-out wrong");
  chk_default_fuse: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_r == ST_LOAD |-> srcSel_r == 4'h2 && sutSel_r == 2'h2 && !div8Fuse_r) else $error("default fuses wrong");
  chk_xtal_range: assert property (@(posedge core_clk) disable iff (!rst_n)
    srcSel_r[3] |-> crystalRange == srcSel_r[3:1]) else $error("crystal range wrong");
  chk_xtal_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
    srcSel_r[3] && sutSel_r == 2'h1 |-> wakeCycles == (srcSel_r[0] ? WAKE_16K : 17'h00102)) else $error("xtal wake");
  chk_lf_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
    srcSel_r == 4'h7 && sutSel_r == 2'h0 |-> wakeCycles == WAKE_32K && wdtCycles == 17'h0) else $error("lf wake");
  chk_rc_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
    srcKind == cssu_pkg::SRC_RC |-> wakeCycles == 17'h00006) else $error("rc wake not 6");
  chk_div_eight: assert property (@(posedge core_clk) disable iff (!rst_n)
    sysClkEn && !div8Fuse_r && state_r != ST_LOAD |=> !sysClkEn [*7] ##1 sysClkEn) else $error("divide by 8");
  chk_hold_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_r == ST_RWDT && !wdtDone |=> coreHold && !coreClkEn) else $error("reset released early");
  chk_wake_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_r == ST_WAKE ##1 state_r == ST_WAKE |-> coreHold && !coreClkEn) else $error("runs before wake delay");
  chk_bad_fallback: assert property (@(posedge core_clk) disable iff (!rst_n)
    srcSel_r == 4'h5 |-> badCode && srcKind == cssu_pkg::SRC_RC) else $error("reserved code not flagged");

endmodule : cssu_clock_startup

// ### verilog/cssu_pkg.sv
package cssu_pkg;

  ////////////////////////////////////////////////////////////////
  // widths
  localparam int          CNT_W          = 17;
  localparam int          ADDR_W         = 12;

  ////////////////////////////////////////////////////////////////
  // fuse encoding and shipped defaults
  localparam logic        FUSE_PROG      = 1'h0;
  localparam logic [3:0]  DEF_SRC_SEL    = 4'h2;
  localparam logic [1:0]  DEF_STARTUP    = 2'h2;
  localparam logic        DEF_DIV8       = 1'h0;
  localparam logic [3:0]  SEL_RC         = 4'h2;
  localparam logic [3:0]  SEL_EXT        = 4'h0;
  localparam logic [2:0]  SEL_LF_HI      = 3'h3;
  localparam logic [1:0]  SUT_NONE       = 2'h0;
  localparam logic [1:0]  SUT_SHORT      = 2'h1;
  localparam logic [1:0]  SUT_LONG       = 2'h2;

  ////////////////////////////////////////////////////////////////
  // cycle counts
  localparam logic [16:0] CNT_NONE       = 17'h00000;
  localparam logic [16:0] WAKE_6         = 17'h00006;
  localparam logic [16:0] WAKE_258       = 17'h00102;
  localparam logic [16:0] WAKE_1K        = 17'h00400;
  localparam logic [16:0] RST_SRC_14     = 17'h0000e;
  localparam logic [16:0] WDT_SHORT      = 17'h01000;
  localparam logic [2:0]  DIV8_LAST      = 3'h7;

  ////////////////////////////////////////////////////////////////
  // register map
  localparam logic [11:0] ADDR_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_STAT      = 12'h004;
  localparam logic [11:0] ADDR_FUSE      = 12'h008;
  localparam logic [31:0] CTRL_RESET     = 32'h00000000;
  localparam int          CTRL_ASY_BIT   = 4;
  localparam int          STAT_HOLD      = 0;
  localparam int          STAT_BAD       = 1;
  localparam int          STAT_KIND      = 2;
  localparam int          STAT_RANGE     = 4;
  localparam int          STAT_INT       = 7;
  localparam int          STAT_START     = 8;
  localparam int          STAT_DIV8      = 9;
  localparam int          FUSE_SEL       = 0;
  localparam int          FUSE_SUT       = 4;
  localparam int          FUSE_DIV8      = 6;

  typedef enum logic [1:0] {SRC_XTAL, SRC_LFXTAL, SRC_RC, SRC_EXT} cssu_src_t;
  typedef enum logic [2:0] {MODE_RUN, MODE_IDLE, MODE_ADCNR, MODE_PDOWN, MODE_PSAVE} cssu_mode_t;

endpackage : cssu_pkg

// ### verilog/cssu_cycle_counter.sv
`timescale 1ns/100ps
module cssu_cycle_counter #(
  parameter int W = 17
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // count control
  input  wire logic         load,
  input  wire logic [W-1:0] loadVal,
  input  wire logic         tick,
  output logic              done
);

  logic [W-1:0] count_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else if (load) begin
      count_r <= loadVal;
    end else if (tick && count_r != '0) begin
      count_r <= count_r - 1'b1;
    end
  end

  assign done = (count_r == '0);

endmodule : cssu_cycle_counter

// ### verilog/cssu_fuse_decode.sv
`timescale 1ns/100ps
module cssu_fuse_decode #(
  parameter logic [16:0] WAKE_16K = 17'h04000,
  parameter logic [16:0] WAKE_32K = 17'h08000,
  parameter logic [16:0] WDT_LONG = 17'h10000
) (
  // fuse fields
  input  wire logic [3:0]       srcSel,
  input  wire logic [1:0]       sutSel,
  // decoded selection
  output cssu_pkg::cssu_src_t   srcKind,
  output logic [2:0]            crystalRange,
  output logic [16:0]           wakeCycles,
  output logic [16:0]           wdtCycles,
  output logic                  badCode
);

  // shared by the low-frequency, rc and external sources
  function automatic logic [16:0] sutExtra(input logic [1:0] s);
    case (s)
      cssu_pkg::SUT_NONE:  sutExtra = cssu_pkg::CNT_NONE;
      cssu_pkg::SUT_SHORT: sutExtra = cssu_pkg::WDT_SHORT;
      default:             sutExtra = WDT_LONG;
    endcase
  endfunction : sutExtra

  always_comb begin
    srcKind      = cssu_pkg::SRC_RC;
    crystalRange = 3'h0;
    wakeCycles   = cssu_pkg::WAKE_6;
    wdtCycles    = sutExtra(sutSel);
    badCode      = 1'b0;
    if (srcSel[3]) begin
      srcKind      = cssu_pkg::SRC_XTAL;
      crystalRange = srcSel[3:1];
      case ({srcSel[0], sutSel})
        3'h0: begin wakeCycles = cssu_pkg::WAKE_258; wdtCycles = cssu_pkg::WDT_SHORT; end
        3'h1: begin wakeCycles = cssu_pkg::WAKE_258; wdtCycles = WDT_LONG; end
        3'h2: begin wakeCycles = cssu_pkg::WAKE_1K;  wdtCycles = cssu_pkg::CNT_NONE; end
        3'h3: begin wakeCycles = cssu_pkg::WAKE_1K;  wdtCycles = cssu_pkg::WDT_SHORT; end
        3'h4: begin wakeCycles = cssu_pkg::WAKE_1K;  wdtCycles = WDT_LONG; end
        3'h5: begin wakeCycles = WAKE_16K;           wdtCycles = cssu_pkg::CNT_NONE; end
        3'h6: begin wakeCycles = WAKE_16K;           wdtCycles = cssu_pkg::WDT_SHORT; end
        default: begin wakeCycles = WAKE_16K;        wdtCycles = WDT_LONG; end
      endcase
    end else if (srcSel[3:1] == cssu_pkg::SEL_LF_HI) begin
      srcKind    = cssu_pkg::SRC_LFXTAL;
      wakeCycles = srcSel[0] ? WAKE_32K : cssu_pkg::WAKE_1K;
      badCode    = (sutSel == 2'h3);
    end else if (srcSel == cssu_pkg::SEL_RC || srcSel == cssu_pkg::SEL_EXT) begin
      srcKind = (srcSel == cssu_pkg::SEL_RC) ? cssu_pkg::SRC_RC : cssu_pkg::SRC_EXT;
      badCode = (sutSel == 2'h3);
    end else begin
      badCode = 1'b1;
    end
    // reserved codes fall back to rc with the longest start-up
    if (badCode) begin
      srcKind      = cssu_pkg::SRC_RC;
      crystalRange = 3'h0;
      wakeCycles   = cssu_pkg::WAKE_6;
      wdtCycles    = WDT_LONG;
    end
  end

endmodule : cssu_fuse_decode

// ### tb/clock_source_select_startup_test.sv
`timescale 1ns/100ps
module clock_source_select_startup_test;
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic [3:0]  selF     = 4'h2;
  logic [1:0]  sutF     = 2'h0;
  logic        divF     = 1'h1;
  logic        srcOsc   = 1'h0;
  logic        wdtOsc   = 1'h0;
  logic        extInt   = 1'h0;
  logic        startC   = 1'h0;
  logic [11:0] paddr    = 12'h000;
  logic        psel     = 1'h0;
  logic        penable  = 1'h0;
  logic        pwrite   = 1'h0;
  logic [31:0] pwdata   = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, coreHold, coreClkEn, ioClkEn, flashClkEn, asyClkEn, adcClkEn, sysClkEn;
  logic [32:0] expQ[$], maskQ[$], mk, e;
  logic [1:0]  kind;
  logic        bt;
  int          bad_count = 0, checks = 0, cyc = 0, n;

  // small counts keep the run short
  cssu_clock_startup #(.WAKE_16K(17'h00010), .WAKE_32K(17'h00020), .WDT_LONG(17'h00040)) i_cssu_clock_startup (
    .core_clk(core_clk), .rst_n(rst_n), .clockSourceSelectFuses(selF), .startupTimeFuses(sutF),
    .divideByEightFuse(divF), .srcOscIn(srcOsc), .wdtOscIn(wdtOsc), .extIntIn(extInt), .startCondIn(startC),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .coreHold(coreHold), .coreClkEn(coreClkEn), .ioClkEn(ioClkEn),
    .flashClkEn(flashClkEn), .asyClkEn(asyClkEn), .adcClkEn(adcClkEn), .sysClkEn(sysClkEn));

  ////////////////////////////////////////////////////////////////
  always #5 core_clk = ~core_clk;

  task automatic tally_and_finish;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // oscillators toggle every cycle so each has an edge every two cycles
  always @(posedge core_clk) begin
    srcOsc <= ~srcOsc;
    wdtOsc <= ~wdtOsc;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // read watcher: oldest note against the answer
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      mk = maskQ.pop_front();
      check({pslverr, prdata} & mk, expQ.pop_front());
    end
  end

  ////////////////////////////////////////////////////////////////
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [32:0] x,
                     input logic [32:0] m);
    if (!w) begin
      expQ.push_back(x & m);
      maskQ.push_back(m);
    end
    paddr <= a; pwrite <= w; pwdata <= d; psel <= 1'b1; penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
    // one idle edge keeps a following call from re-driving psel in this time step
    @(posedge core_clk);
  endtask : apb

  task automatic boot(input logic [3:0] s, input logic [1:0] u);
    selF <= s; sutF <= u; divF <= 1'($urandom); rst_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    check(coreHold, 1'b1);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask : boot

  task automatic waitHold(input int lim, input logic v);
    n = 0;
    while (coreHold !== v && n < lim) begin
      @(posedge core_clk);
      n++;
    end
  endtask : waitHold

  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h5c3a));
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    for (int c = 0; c < 16; c++) begin
      boot(4'(c), 2'((c >> 1) & 1));
      bt = (c == 1 || c == 3 || c == 4 || c == 5);
      kind = (c >= 8) ? 2'h0 : (c >= 6) ? 2'h1 : (c == 0) ? 2'h3 : 2'h2;
      e = 33'(bt) << 1 | 33'(kind) << 2 | 33'(!divF) << 9 | ((c >= 8) ? 33'(c >> 1) << 4 : 33'h0);
      apb(cssu_pkg::ADDR_STAT, 1'b0, 32'h0, e, (c >= 8) ? 33'h27e : 33'h20e);
      apb(cssu_pkg::ADDR_FUSE, 1'b0, 32'h0, {26'h0, divF, 2'((c >> 1) & 1), 4'(c)}, 33'h7f);
    end
    boot(4'h2, 2'h3);
    apb(cssu_pkg::ADDR_STAT, 1'b0, 32'h0, 33'ha, 33'he);
    apb(12'h00c, 1'b0, 32'h0, {1'b1, 32'h0}, {33{1'b1}});
    apb(cssu_pkg::ADDR_FUSE, 1'b1, $urandom, 33'h0, 33'h0);
    apb(cssu_pkg::ADDR_FUSE, 1'b0, 32'h0, {26'h0, divF, 6'h32}, 33'h7f);
    apb(cssu_pkg::ADDR_CTRL, 1'b0, 32'h0, {1'b0, cssu_pkg::CTRL_RESET}, {33{1'b1}});
    boot(4'h2, 2'h1);
    repeat (8000) @(posedge core_clk);
    check(coreHold, 1'b1);
    waitHold(1000, 1'b0);
    check(coreHold, 1'b0);
    boot(4'h2, 2'h2);
    repeat (100) @(posedge core_clk);
    check(coreHold, 1'b1);
    waitHold(200, 1'b0);
    repeat (2) @(posedge core_clk);
    check(coreClkEn, 1'b1);
    check(flashClkEn, 1'b1);
    n = 0;
    repeat (64) begin
      @(posedge core_clk);
      n += int'(sysClkEn === 1'b1);
    end
    check(33'(n), divF ? 33'd64 : 33'd8);
    // long wake 1024 edges versus 32 edges
    for (int i = 0; i < 2; i++) begin
      boot(i ? 4'h6 : 4'h7, 2'h0);
      waitHold(400, 1'b0);
      apb(cssu_pkg::ADDR_CTRL, 1'b1, 32'h13, 33'h0, 33'h0);
      repeat (4) @(posedge core_clk);
      check(coreClkEn, 1'b0);
      check(ioClkEn, 1'b0);
      check(asyClkEn, 1'b1);
      extInt <= 1'b1;
      repeat (4) @(posedge core_clk);
      extInt <= 1'b0;
      repeat (i ? 1800 : 50) @(posedge core_clk);
      check(coreHold, 1'b1);
      waitHold(3000, 1'b0);
      check(coreHold, 1'b0);
      apb(cssu_pkg::ADDR_CTRL, 1'b0, 32'h0, 33'h10, 33'h17);
      apb(cssu_pkg::ADDR_STAT, 1'b0, 32'h0, 33'h80, 33'h80);
      apb(cssu_pkg::ADDR_STAT, 1'b1, $urandom | 32'h180, 33'h0, 33'h0);
      apb(cssu_pkg::ADDR_STAT, 1'b0, 32'h0, 33'h0, 33'h180);
    end
    apb(cssu_pkg::ADDR_CTRL, 1'b1, 32'h2, 33'h0, 33'h0);
    repeat (4) @(posedge core_clk);
    check({adcClkEn, coreClkEn, ioClkEn}, 33'h4);
    startC <= 1'b1;
    repeat (8) @(posedge core_clk);
    startC <= 1'b0;
    check(coreClkEn, 1'b1);
    apb(cssu_pkg::ADDR_STAT, 1'b0, 32'h0, 33'h100, 33'h100);
    repeat (2) @(posedge core_clk);
    check(33'(expQ.size()), 33'h0);
    tally_and_finish();
  end
endmodule : clock_source_select_startup_test
